/* File: rtl/mbp_memory_bus_pin_control.sv */
`timescale 1ns/1ns
// How it works
// R01: Stall input sampled each bus rising edge.
// R02: Memory drives stall low before edge.
// R03: Odd parity per byte lane output.
// R04: Parity valid for writes in low phase.
// R05: Parity undefined during reads, forced zero.
// R06: Sequential flag is inverted access request.
// R07: Async select: clock input, inverted output low.
// R08: Sync select: drive clock and inverse.
// R09: Sync select held static by system.
// R10: Ratio set select picks divide ratios.
// R11: Undriven ratio select means legacy set.
// R12: Bypass picks external core clock source.
// R13: Test reset pulsed low by system.
// R14: Bus clock equals core over ratio plus two.
// R15: Access request changes in low phase.
// R16: Each low stall sample adds a cycle.
module mbp_memory_bus_pin_control (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clock_sync_select,
    input wire logic [2:0] i_mem_clock_ratio_pins,
    input wire logic [2:0] i_core_clock_ratio_pins,
    input wire logic i_loop_ratio_set_select,
    input wire logic i_core_clock_bypass,
    input wire logic i_external_core_clock,
    input wire logic i_pll_core_clock,
    input wire logic i_test_port_reset_n,
    input wire logic i_mem_bus_clock_in,
    input wire logic i_bus_stall_n,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [31:0] i_req_wdata,
    output logic o_req_done,
    output logic o_mem_bus_clock_out,
    output logic o_mem_bus_clock_oe,
    output logic o_mem_bus_clock_inverted,
    output logic o_mem_access_pending_n,
    output logic o_burst_follow_flag,
    output logic o_write_not_read,
    output logic [31:0] o_data_out,
    output logic [3:0] o_parity,
    output logic o_core_clock_sel,
    output logic o_loop_ratio_set,
    output logic [2:0] o_core_ratio,
    output logic o_test_port_active
);

    // Core clock ticks per bus period, one more than the ratio pins plus offset minus one.
    logic [3:0] div_limit;
    // Divider counter and derived synchronous bus clock level.
    logic [3:0] div_cnt_reg, div_cnt_next;
    logic mclk_reg, mclk_next;
    // Previous level of the active bus clock, for edge detection.
    logic mclk_prev_reg, mclk_prev_next;
    // Selected bus clock level, edges derived from it.
    logic bus_clk;
    logic bus_rise;
    logic bus_fall;
    // Access sequencer.
    mbp_pkg::mbp_state_t state_reg, state_next;
    // Registered pin outputs and their next values.
    logic mreq_n_reg, mreq_n_next;
    logic seq_reg, seq_next;
    logic wnr_reg, wnr_next;
    logic [31:0] data_reg, data_next;
    logic [3:0] par_reg, par_next;
    logic done_reg, done_next;
    logic mem_bus_clock_inverted_reg, mem_bus_clock_inverted_next;
    logic oe_reg, oe_next;
    logic cfg_sel_reg, cfg_sel_next;
    logic cfg_set_reg, cfg_set_next;
    logic [2:0] cfg_ratio_reg, cfg_ratio_next;
    logic tpa_reg, tpa_next;
    // Pending request latch, so a request is not lost between bus edges.
    logic pend_reg, pend_next;
    logic pend_wr_reg, pend_wr_next;
    logic [31:0] pend_data_reg, pend_data_next;

    // Odd parity over one byte: the lane bit makes the ones count odd.
    function automatic logic [3:0] odd_parity(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < mbp_pkg::LANES; i++) begin
            p[i] = ~(^d[i*8 +: 8]);
        end
        return p;
    endfunction : odd_parity

    // Divide limit: ratio plus two periods of core clock, high for the first half, rounded up.
    assign div_limit = {1'b0, i_mem_clock_ratio_pins} + mbp_pkg::DIV_OFFSET - 4'h1;

    // In async mode the pin is an input; otherwise our own divided clock is used.
    assign bus_clk = i_clock_sync_select ? mclk_reg : i_mem_bus_clock_in;
    assign bus_rise = bus_clk & ~mclk_prev_reg;
    assign bus_fall = ~bus_clk & mclk_prev_reg;

    // Clock divider and clock pin drive.
    always_comb begin
        div_cnt_next = div_cnt_reg;
        mclk_next = mclk_reg;
        mclk_prev_next = bus_clk;
        // R14 divide by ratio
        if (i_clock_sync_select) begin
            // The counter covers a full period; the clock is high for the first half, rounded up.
            if (div_cnt_reg >= div_limit) begin
                div_cnt_next = mbp_pkg::DIV_CNT_RESET;
            end else begin
                div_cnt_next = div_cnt_reg + 4'h1;
            end
            mclk_next = (div_cnt_next <= (div_limit >> 1));
        end else begin
            div_cnt_next = mbp_pkg::DIV_CNT_RESET;
            mclk_next = 1'b0;
        end
        // R07 async holds inverse low
        // R08 sync drives both clocks
        oe_next = i_clock_sync_select;
        mem_bus_clock_inverted_next = i_clock_sync_select ? ~mclk_next : 1'b0;
    end

    // Divider registers; the select is assumed static, so no resynchronisation is needed.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_cnt_reg <= mbp_pkg::DIV_CNT_RESET;
            mclk_reg <= 1'b0;
            mclk_prev_reg <= 1'b0;
            oe_reg <= 1'b0;
            mem_bus_clock_inverted_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            mclk_reg <= mclk_next;
            mclk_prev_reg <= mclk_prev_next;
            oe_reg <= oe_next;
            mem_bus_clock_inverted_reg <= mem_bus_clock_inverted_next;
        end
    end

    // Access sequencer: announce in low phase, run the access, stretch on stall.
    always_comb begin
        state_next = state_reg;
        mreq_n_next = mreq_n_reg;
        seq_next = seq_reg;
        wnr_next = wnr_reg;
        data_next = data_reg;
        par_next = par_reg;
        done_next = 1'b0;
        pend_next = pend_reg;
        pend_wr_next = pend_wr_reg;
        pend_data_next = pend_data_reg;
        // A new request is held until the sequencer takes it.
        if (i_req_valid && !pend_reg) begin
            pend_next = 1'b1;
            pend_wr_next = i_req_write;
            pend_data_next = i_req_wdata;
        end
        unique case (state_reg)
            mbp_pkg::MBP_IDLE: begin
                // R15 request in low phase
                if (bus_fall && pend_reg) begin
                    mreq_n_next = 1'b0;
                    wnr_next = pend_wr_reg;
                    data_next = pend_data_reg;
                    pend_next = 1'b0;
                    state_next = mbp_pkg::MBP_ANNOUNCE;
                end
            end
            mbp_pkg::MBP_ANNOUNCE: begin
                // The access cycle begins at the next rising edge.
                if (bus_rise) begin
                    state_next = mbp_pkg::MBP_ACCESS;
                end
            end
            mbp_pkg::MBP_ACCESS: begin
                // R01 sample stall on rise
                // R16 one cycle per low
                if (bus_rise && i_bus_stall_n) begin
                    done_next = 1'b1;
                    state_next = mbp_pkg::MBP_IDLE;
                end
                if (bus_fall && !pend_reg && (state_next == mbp_pkg::MBP_ACCESS)) begin
                    mreq_n_next = mreq_n_reg;
                end
            end
        endcase
        // Request is withdrawn in the low phase after completion.
        if (state_reg == mbp_pkg::MBP_IDLE && bus_fall && !pend_reg) begin
            mreq_n_next = 1'b1;
        end
        // R06 inverse while clock high
        if (bus_clk) begin
            seq_next = ~mreq_n_reg;
        end
        // R03 odd lane parity
        // R04 valid in low phase
        // R05 reads give zero
        if (!bus_clk) begin
            par_next = wnr_reg ? odd_parity(data_reg) : 4'h0;
        end
    end

    // Sequencer and pin registers.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= mbp_pkg::MBP_IDLE;
            mreq_n_reg <= mbp_pkg::MREQ_N_RESET;
            seq_reg <= 1'b0;
            wnr_reg <= 1'b0;
            data_reg <= 32'h0;
            par_reg <= 4'h0;
            done_reg <= 1'b0;
            pend_reg <= 1'b0;
            pend_wr_reg <= 1'b0;
            pend_data_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            mreq_n_reg <= mreq_n_next;
            seq_reg <= seq_next;
            wnr_reg <= wnr_next;
            data_reg <= data_next;
            par_reg <= par_next;
            done_reg <= done_next;
            pend_reg <= pend_next;
            pend_wr_reg <= pend_wr_next;
            pend_data_reg <= pend_data_next;
        end
    end

    // Clock source and ratio set selection, registered for clean outputs.
    always_comb begin
        // R12 bypass selects external core clock
        cfg_sel_next = i_core_clock_bypass;
        // R10 choose ratio set
        // R11 high means legacy
        cfg_set_next = (i_loop_ratio_set_select == mbp_pkg::RATIO_SET_LEGACY);
        cfg_ratio_next = i_core_clock_ratio_pins;
        // The test port is usable only once its own reset was released.
        tpa_next = i_test_port_reset_n;
    end

    // Configuration registers; the actual clock mux sits in the clock tree.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_sel_reg <= 1'b0;
            cfg_set_reg <= mbp_pkg::RATIO_SET_LEGACY;
            cfg_ratio_reg <= 3'h0;
            tpa_reg <= 1'b0;
        end else begin
            cfg_sel_reg <= cfg_sel_next;
            cfg_set_reg <= cfg_set_next;
            cfg_ratio_reg <= cfg_ratio_next;
            tpa_reg <= tpa_next;
        end
    end

    assign o_req_done = done_reg;
    assign o_mem_bus_clock_out = mclk_reg;
    assign o_mem_bus_clock_oe = oe_reg;
    assign o_mem_bus_clock_inverted = mem_bus_clock_inverted_reg;
    assign o_mem_access_pending_n = mreq_n_reg;
    assign o_burst_follow_flag = seq_reg;
    assign o_write_not_read = wnr_reg;
    assign o_data_out = data_reg;
    assign o_parity = par_reg;
    assign o_core_clock_sel = cfg_sel_reg;
    assign o_loop_ratio_set = cfg_set_reg;
    assign o_core_ratio = cfg_ratio_reg;
    assign o_test_port_active = tpa_reg;

    // Completion only on a rising edge with stall high.
    sequence s_done_cause;
        $past(bus_rise) && $past(i_bus_stall_n) && ($past(state_reg) == mbp_pkg::MBP_ACCESS);
    endsequence
    AST_STALL_EXTENDS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R16
        o_req_done |-> s_done_cause) else $error("Access finished without a high stall sample.");
    AST_STALL_SAMPLED: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R01
        (state_reg == mbp_pkg::MBP_ACCESS && bus_rise && !i_bus_stall_n) |=> !o_req_done)
        else $error("Low stall sample did not extend the access.");
    AST_PARITY_ODD: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R03
        ($past(!bus_clk) && $past(wnr_reg)) |-> (o_parity == odd_parity($past(data_reg))))
        else $error("Parity is not odd per lane.");
    AST_PARITY_READ: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R05
        ($past(!bus_clk) && $past(!wnr_reg)) |-> (o_parity == 4'h0)) else $error("Read parity not zero.");
    AST_SEQ_INVERSE: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R06
        $past(bus_clk) |-> (o_burst_follow_flag == ~$past(mreq_n_reg))) else $error("Sequential flag wrong.");
    AST_ASYNC_CLOCK: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R07
        $past(!i_clock_sync_select) |-> (!o_mem_bus_clock_inverted && !o_mem_bus_clock_oe))
        else $error("Async mode drives clock pins.");
    // The first edge after reset still shows reset levels, so the registered pins are skipped there.
    AST_SYNC_CLOCK: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R08
        ($past(i_clock_sync_select) && $past(i_reset_n))
        |-> (o_mem_bus_clock_oe && (o_mem_bus_clock_inverted != mclk_reg)))
        else $error("Sync mode clock pins wrong.");
    AST_BYPASS: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R12
        $past(i_reset_n) |-> (o_core_clock_sel == $past(i_core_clock_bypass)))
        else $error("Bypass select not followed.");
    AST_RATIO_SET: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R10
        $past(i_reset_n) |-> (o_loop_ratio_set == ($past(i_loop_ratio_set_select) == mbp_pkg::RATIO_SET_LEGACY)))
        else $error("Ratio set select not followed.");
    // Every bus clock period starts from a cleared divider count; the first short period after reset is skipped.
    AST_DIV_WRAP: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R14
        ($past(i_reset_n, 2) && i_clock_sync_select && $rose(o_mem_bus_clock_out))
        |-> (div_cnt_reg == mbp_pkg::DIV_CNT_RESET)) else $error("Bus clock rose away from the period start.");
    AST_REQ_LOW_PHASE: assert property (@(posedge i_clock) disable iff (!i_reset_n) // R15
        $fell(o_mem_access_pending_n) |-> $past(bus_fall)) else $error("Request changed outside low phase.");

endmodule : mbp_memory_bus_pin_control

/* File: rtl/mbp_pkg.sv */
package mbp_pkg;
    // Width of the external data bus and its byte lanes.
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    // The memory clock divides the core clock by the ratio pins plus this offset.
    localparam logic [3:0] DIV_OFFSET = 4'h2;
    // Reset values of the pin-facing state.
    localparam logic MREQ_N_RESET = 1'b1;
    localparam logic [3:0] DIV_CNT_RESET = 4'h0;
    // Loop ratio sets: legacy set is chosen by a high select level.
    localparam logic RATIO_SET_LEGACY = 1'b1;
    // Bus access sequencer states.
    typedef enum logic [1:0] {MBP_IDLE, MBP_ANNOUNCE, MBP_ACCESS} mbp_state_t;
endpackage : mbp_pkg

/* File: verif/mbp_memory_model.sv */
`timescale 1ns/1ns
// Memory side: holds each access for a chosen number of stalled bus rising edges.
module mbp_memory_model (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_bus_clock,
    input wire logic i_pending_n,
    input wire logic [1:0] i_stall_cycles,
    output logic o_bus_stall_n
);
    logic clk_prev; // Bus clock level at the last core edge.
    logic [2:0] left; // Bus falls still to pass while stalling, one more than the stalls asked for.
    assign o_bus_stall_n = i_pending_n | (left == 3'h0);
    // While the request is pending the count moves only on bus falls, so the level is settled well ahead of each rise.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_prev <= 1'b0;
            left <= 3'h0;
        end else begin
            clk_prev <= i_bus_clock;
            if (i_pending_n) begin
                // The fall after the announcing rise uses up the extra count, so exactly the asked number of later rises stall.
                left <= {1'b0, i_stall_cycles} + 3'h1;
            end else if (clk_prev && !i_bus_clock && left != 3'h0) begin
                left <= left - 3'h1;
            end
        end
    end
endmodule : mbp_memory_model

/* File: verif/tb.sv */
`timescale 1ns/1ns
module tb;
    logic i_clock, i_reset_n, i_clock_sync_select, i_loop_ratio_set_select, i_core_clock_bypass;
    logic i_external_core_clock, i_pll_core_clock, i_test_port_reset_n, i_mem_bus_clock_in, i_bus_stall_n;
    logic i_req_valid, i_req_write, o_req_done, o_mem_bus_clock_out, o_mem_bus_clock_oe;
    logic o_mem_bus_clock_inverted, o_mem_access_pending_n, o_burst_follow_flag, o_write_not_read;
    logic o_core_clock_sel, o_loop_ratio_set, o_test_port_active;
    logic [2:0] i_mem_clock_ratio_pins, i_core_clock_ratio_pins, o_core_ratio;
    logic [31:0] i_req_wdata, o_data_out;
    logic [3:0] o_parity;
    logic [1:0] stall_cycles; // Stall count handed to the memory model.
    logic clk_prev; // Watcher's last bus clock level.
    logic [2:0] rises; // Bus rising edges seen while an access is pending.
    // One note for each access, taken off when its done pulse appears.
    typedef struct packed {
        logic wr;
        logic [31:0] data;
        logic [3:0] par;
        logic [2:0] rises;
    } mbp_note_t;
    mbp_note_t notes[$];
    int mismatches = 0;
    int num_checks = 0;

    mbp_memory_bus_pin_control mbp_memory_bus_pin_control_inst (.*);
    mbp_memory_model mbp_memory_model_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_bus_clock(o_mem_bus_clock_out), .i_pending_n(o_mem_access_pending_n),
        .i_stall_cycles(stall_cycles), .o_bus_stall_n(i_bus_stall_n));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // Clock sources and the async bus clock keep moving so no input sits idle.
    always @(posedge i_clock) begin
        i_external_core_clock <= 1'($urandom);
        i_pll_core_clock <= 1'($urandom);
        i_mem_bus_clock_in <= ($time % 48) < 24;
    end

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Mode pins only change under reset, since the bus clock mode must stay static.
    task automatic restart(input logic sync, input logic [2:0] ratio);
        i_reset_n <= 1'b0;
        i_test_port_reset_n <= 1'b0;
        i_clock_sync_select <= sync;
        i_mem_clock_ratio_pins <= ratio;
        repeat (10) @(posedge i_clock);
        check_val("pending_n in reset", 32'(mbp_pkg::MREQ_N_RESET), 32'(o_mem_access_pending_n));
        i_reset_n <= 1'b1;
        i_test_port_reset_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        check_val("test port active", 32'h1, 32'(o_test_port_active));
    endtask : restart

    // Watches the bus clock pins for 40 cycles and measures its period.
    task automatic check_clock(input logic sync, input logic [2:0] ratio);
        int first;
        logic last;
        first = -1;
        last = 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(posedge i_clock);
            if (o_mem_bus_clock_out === 1'b1 && last === 1'b0) begin
                if (first >= 0) check_val("bus clock period", 32'(ratio) + 32'h2, 32'(k - first));
                first = k;
            end
            last = o_mem_bus_clock_out;
            check_val("clock enable", 32'(sync), 32'(o_mem_bus_clock_oe));
            check_val("inverted clock", 32'(sync & ~last), 32'(o_mem_bus_clock_inverted));
        end
    endtask : check_clock

    task automatic check_pins;
        logic [2:0] cr;
        logic ls, byp;
        cr = 3'($urandom);
        ls = 1'($urandom);
        byp = 1'($urandom);
        i_core_clock_ratio_pins <= cr;
        i_loop_ratio_set_select <= ls;
        i_core_clock_bypass <= byp;
        repeat (3) @(posedge i_clock);
        check_val("ratio set", 32'(ls == mbp_pkg::RATIO_SET_LEGACY), 32'(o_loop_ratio_set));
        check_val("core clock select", 32'(byp), 32'(o_core_clock_sel));
        check_val("core ratio", 32'(cr), 32'(o_core_ratio));
    endtask : check_pins

    // One access; the request data stay put until the done pulse.
    task automatic access(input logic wr, input logic [31:0] data, input logic [1:0] stalls);
        mbp_note_t note;
        int n;
        // The announcing rise and the closing rise come on top of the stalled ones.
        note = {wr, data, ~{^data[31:24], ^data[23:16], ^data[15:8], ^data[7:0]}, 3'(stalls) + 3'h2};
        notes.push_back(note);
        stall_cycles <= stalls;
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_wdata <= data;
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        n = 0;
        while (o_req_done !== 1'b1 && n < 300) begin
            @(posedge i_clock);
            n++;
        end
        // Wait for the request line to rise again, so the memory model takes the next stall count.
        while (o_mem_access_pending_n !== 1'b1 && n < 300) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 300) check_val("done seen", 32'h1, 32'h0);
        @(posedge i_clock);
    endtask : access

    // Counts bus rises during each access and checks the outputs when it ends.
    always @(posedge i_clock) begin : watch
        mbp_note_t note;
        if (o_mem_access_pending_n !== 1'b0) rises = 3'h0;
        else if (o_mem_bus_clock_out === 1'b1 && clk_prev === 1'b0) rises = rises + 3'h1;
        clk_prev = o_mem_bus_clock_out;
        if (o_req_done === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            check_val("write_not_read", 32'(note.wr), 32'(o_write_not_read));
            if (note.wr) check_val("data out", note.data, o_data_out);
            if (note.wr) check_val("parity", 32'(note.par), 32'(o_parity));
            check_val("bus rises", 32'(note.rises), 32'(rises));
            check_val("burst flag", 32'(!o_mem_access_pending_n), 32'(o_burst_follow_flag));
        end
    end

    initial begin
        {i_reset_n, i_clock_sync_select, i_mem_clock_ratio_pins, i_core_clock_ratio_pins} = '0;
        {i_loop_ratio_set_select, i_core_clock_bypass} = 2'h0;
        {i_test_port_reset_n, i_req_valid, i_req_write, i_req_wdata} = '0;
        stall_cycles = 2'h0;
        void'($urandom(78));
        restart(1'b0, 3'h0);
        check_clock(1'b0, 3'h0);
        check_pins();
        for (int r = 0; r < 8; r++) begin
            restart(1'b1, 3'(r));
            check_clock(1'b1, 3'(r));
            check_pins();
            for (int a = 0; a < 4; a++) access(1'($urandom), $urandom, 2'(a));
        end
        complete_run();
    end

    // Cuts a hang short well beyond the expected run of under two thousand cycles.
    initial begin
        #(8 * 20000);
        mismatches++;
        complete_run();
    end
endmodule : tb
